// ===== design/swc_pkg.sv
// Shared constants and types of the sleep and wake controller.
// Assumes a 20 MHz APB clock and a core oscillator period equal to it.
package swc_pkg;

  // APB register byte offsets
  localparam logic [7:0] SWC_OFS_STATUS = 8'h00;
  localparam logic [7:0] SWC_OFS_INTCTL = 8'h04;
  localparam logic [7:0] SWC_OFS_IRQEN = 8'h08;
  localparam logic [7:0] SWC_OFS_CONFIG = 8'h0C;
  localparam logic [7:0] SWC_OFS_STATE = 8'h10;

  // Core status and interrupt control field positions
  localparam int SWC_ST_PD_BIT = 3;
  localparam int SWC_ST_TO_BIT = 4;
  localparam int SWC_IC_GIE_BIT = 7;

  // State register field positions
  localparam int SWC_SR_GATE_BIT = 2;
  localparam int SWC_SR_PEND_BIT = 3;

  // Configuration field positions
  localparam int SWC_CF_WDT_EN_BIT = 0;
  localparam int SWC_CF_OSC_LSB = 1;
  localparam int SWC_CF_EXTERNAL_RESET_PIN_EN_BIT = 3;
  localparam int SWC_CF_BOR_EN_BIT = 4;

  // Oscillator modes; only the crystal kinds need a start-up delay
  typedef enum logic [1:0] {
    SWC_OSC_RC,
    SWC_OSC_CRYSTAL,
    SWC_OSC_HS_CRYSTAL,
    SWC_OSC_LP_CRYSTAL
  } swc_osc_type;

  typedef struct packed {
    logic bor_en;
    logic ext_reset_en;
    swc_osc_type osc_mode;
    logic wdt_en;
  } swc_cfg_type;

  localparam swc_cfg_type SWC_CFG_RESET = '{bor_en: 1'b1, ext_reset_en: 1'b1, osc_mode: SWC_OSC_RC, wdt_en: 1'b0};

  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_OST,
    SWC_RESUME
  } swc_state_type;

  // Timing
  localparam int SWC_CLK_PERIOD_NS = 50;
  localparam int SWC_TOSC_PERIOD_NS = 50;
  localparam int SWC_OST_TOSC = 1024;
  localparam int SWC_OST_CYCLES = (SWC_OST_TOSC * SWC_TOSC_PERIOD_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
  localparam logic [12:0] SWC_ISR_VECTOR = 13'h0004;

endpackage : swc_pkg

// ===== design/swc_sleep_ctrl.sv
// Sleep and wake controller: gates the core clock, keeps the watchdog and
// the power-down and watchdog-expiry flags, and sequences wake-up.
// Assumes the core pulses sleep_exec for one cycle per power-down instruction.
`timescale 1ns/10ps

module swc_sleep_ctrl #(
  parameter int IRQ_N = 8,
  parameter int WDT_W = 16,
  parameter int WDT_TIMEOUT = 65535
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core instruction stream and interrupt sources
  input wire logic sleep_exec,
  input wire logic [IRQ_N-1:0] irq_flags,
  // Reset sources
  input wire logic ext_reset_req,
  input wire logic brownout_req,
  input wire logic por_req,
  // Core control
  output logic cpu_clk_gate,
  output logic core_reset,
  output logic wdt_reset,
  output logic prefetch_req,
  output logic wake_resume,
  output logic isr_call,
  output logic [12:0] isr_vector,
  // Held domains
  output logic io_hold,
  output logic lf_osc_run,
  output logic timer_osc_run,
  output logic adc_rc_run
);

  swc_pkg::swc_state_type state_r;
  swc_pkg::swc_cfg_type cfg_r;
  logic pd_flag_r;
  logic to_flag_r;
  logic gie_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic [WDT_W-1:0] wdt_r;
  logic [10:0] ost_cnt_r;
  logic wake_gie_r;

  logic irq_pending;
  logic wdt_expire;
  logic reset_any;
  logic enter_sleep;
  logic sleep_noop;
  logic wake_now;
  logic crystal;
  logic ost_done;
  logic apb_wr;
  logic apb_setup;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  assign irq_pending = |(irq_flags & irq_en_r);
  assign wdt_expire = cfg_r.wdt_en && (wdt_r == WDT_W'(WDT_TIMEOUT));
  assign reset_any = por_req || (ext_reset_req && cfg_r.ext_reset_en) || (brownout_req && cfg_r.bor_en);
  assign sleep_noop = !gie_r && irq_pending;
  assign enter_sleep = (state_r == swc_pkg::SWC_RUN) && sleep_exec && !sleep_noop && !reset_any;
  // Global enable plays no part in the wake decision
  assign wake_now = (state_r == swc_pkg::SWC_SLEEP) && (irq_pending || wdt_expire);
  assign crystal = cfg_r.osc_mode != swc_pkg::SWC_OSC_RC;
  assign ost_done = ost_cnt_r == 11'(swc_pkg::SWC_OST_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= swc_pkg::SWC_RUN;
    end else if (reset_any) begin
      state_r <= swc_pkg::SWC_RUN;
    end else begin
      unique case (state_r)
        swc_pkg::SWC_RUN: begin
          if (enter_sleep) begin
            state_r <= swc_pkg::SWC_SLEEP;
          end
        end
        swc_pkg::SWC_SLEEP: begin
          if (wake_now) begin
            state_r <= crystal ? swc_pkg::SWC_OST : swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_OST: begin
          if (ost_done) begin
            state_r <= swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_RESUME: begin
          state_r <= swc_pkg::SWC_RUN;
        end
      endcase
    end
  end

  // Oscillator start-up counter; only advances in the start-up state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_r <= 11'h000;
    end else if (state_r == swc_pkg::SWC_OST) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
    end else begin
      ost_cnt_r <= 11'h000;
    end
  end

  // Global enable captured at wake so a later write cannot redirect the resume
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_gie_r <= 1'b0;
    end else if (wake_now) begin
      wake_gie_r <= gie_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_r <= '0;
    end else if (reset_any || enter_sleep || wake_now || wdt_expire) begin
      wdt_r <= '0;
    end else if (cfg_r.wdt_en) begin
      wdt_r <= wdt_r + WDT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: power-on value has both flags set

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_flag_r <= 1'b1;
      to_flag_r <= 1'b1;
    end else if (por_req) begin
      pd_flag_r <= 1'b1;
      to_flag_r <= 1'b1;
    end else if (enter_sleep) begin
      pd_flag_r <= 1'b0;
      to_flag_r <= 1'b1;
    end else if (wdt_expire) begin
      to_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_gate <= 1'b0;
    end else if (reset_any) begin
      cpu_clk_gate <= 1'b0;
    end else if (enter_sleep) begin
      cpu_clk_gate <= 1'b1;
    end else if (state_r == swc_pkg::SWC_RESUME) begin
      cpu_clk_gate <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b1;
      wdt_reset <= 1'b0;
    end else begin
      core_reset <= reset_any;
      wdt_reset <= wdt_expire && (state_r == swc_pkg::SWC_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_req <= 1'b0;
      wake_resume <= 1'b0;
      isr_call <= 1'b0;
    end else begin
      prefetch_req <= enter_sleep;
      wake_resume <= (state_r == swc_pkg::SWC_RESUME) && !reset_any;
      isr_call <= (state_r == swc_pkg::SWC_RESUME) && !reset_any && wake_gie_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_vector <= 13'h0000;
    end else begin
      isr_vector <= swc_pkg::SWC_ISR_VECTOR;
    end
  end

  // Pins hold from entry until the clock gate opens again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hold <= 1'b0;
    end else if (reset_any || state_r == swc_pkg::SWC_RESUME) begin
      io_hold <= 1'b0;
    end else if (enter_sleep) begin
      io_hold <= 1'b1;
    end
  end

  // Low-power clock sources are never stopped by sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_osc_run <= 1'b0;
      timer_osc_run <= 1'b0;
      adc_rc_run <= 1'b0;
    end else begin
      lf_osc_run <= 1'b1;
      timer_osc_run <= 1'b1;
      adc_rc_run <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, answer registered in the setup cycle

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign addr_ok = (paddr == swc_pkg::SWC_OFS_STATUS) || (paddr == swc_pkg::SWC_OFS_INTCTL) ||
                   (paddr == swc_pkg::SWC_OFS_IRQEN) || (paddr == swc_pkg::SWC_OFS_CONFIG) ||
                   (paddr == swc_pkg::SWC_OFS_STATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        swc_pkg::SWC_OFS_STATUS: begin
          prdata[swc_pkg::SWC_ST_PD_BIT] <= pd_flag_r;
          prdata[swc_pkg::SWC_ST_TO_BIT] <= to_flag_r;
        end
        swc_pkg::SWC_OFS_INTCTL: begin
          prdata[swc_pkg::SWC_IC_GIE_BIT] <= gie_r;
        end
        swc_pkg::SWC_OFS_IRQEN: begin
          prdata[IRQ_N-1:0] <= irq_en_r;
        end
        swc_pkg::SWC_OFS_CONFIG: begin
          prdata[$bits(swc_pkg::swc_cfg_type)-1:0] <= cfg_r;
        end
        swc_pkg::SWC_OFS_STATE: begin
          prdata[$bits(swc_pkg::swc_state_type)-1:0] <= state_r;
          prdata[swc_pkg::SWC_SR_GATE_BIT] <= cpu_clk_gate;
          prdata[swc_pkg::SWC_SR_PEND_BIT] <= irq_pending;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_r <= 1'b0;
      irq_en_r <= '0;
      cfg_r <= swc_pkg::SWC_CFG_RESET;
    end else if (apb_wr) begin
      if (paddr == swc_pkg::SWC_OFS_INTCTL) begin
        gie_r <= pwdata[swc_pkg::SWC_IC_GIE_BIT];
      end
      if (paddr == swc_pkg::SWC_OFS_IRQEN) begin
        irq_en_r <= pwdata[IRQ_N-1:0];
      end
      if (paddr == swc_pkg::SWC_OFS_CONFIG) begin
        cfg_r <= swc_pkg::swc_cfg_type'(pwdata[$bits(swc_pkg::swc_cfg_type)-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_noop_keeps_state: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_RUN && sleep_exec && sleep_noop && !reset_any) |=>
      (state_r == swc_pkg::SWC_RUN && $stable(pd_flag_r) && !cpu_clk_gate))
    else $error("no-op sleep changed state or flags");

  a_entry_flags: assert property (@(posedge pclk) disable iff (!presetn)
    enter_sleep |=> (!pd_flag_r && to_flag_r))
    else $error("flags wrong after sleep entry");

  a_entry_wdt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    enter_sleep |=> (wdt_r == '0))
    else $error("watchdog not cleared on entry");

  a_gate_on_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_SLEEP) |-> cpu_clk_gate)
    else $error("core clock running while asleep");

  a_only_on_instr: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_RUN && !sleep_exec) |=> state_r != swc_pkg::SWC_SLEEP)
    else $error("sleep without instruction");

  a_irq_wake_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_SLEEP && irq_pending && !crystal && !reset_any) |=>
      (state_r == swc_pkg::SWC_RESUME) ##1 (!cpu_clk_gate && wake_resume))
    else $error("interrupt wake not immediate");

  a_wake_wdt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now |=> (wdt_r == '0))
    else $error("watchdog not cleared on wake");

  a_isr_vector: assert property (@(posedge pclk) disable iff (!presetn)
    isr_call |-> (wake_resume && isr_vector == 13'h0004 && $past(wake_gie_r)))
    else $error("service call without global enable or wrong vector");

  a_prefetch_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    enter_sleep |=> (prefetch_req && cpu_clk_gate))
    else $error("no prefetch on entry");

  a_ost_length: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_OST && $past(state_r) == swc_pkg::SWC_OST && !ost_done) |->
      (ost_cnt_r != 11'h000 && cpu_clk_gate))
    else $error("start-up delay cut short");

  a_reset_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (reset_any && state_r == swc_pkg::SWC_SLEEP) |=> (core_reset && !cpu_clk_gate && !io_hold))
    else $error("reset did not reset core from sleep");

  a_io_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::SWC_SLEEP) |-> io_hold)
    else $error("pins not held during sleep");

endmodule : swc_sleep_ctrl

// ===== bench/sleep_wake_controller_tb.sv
// Self-checking bench of the sleep and wake controller.
// Drives APB, the instruction pulse, interrupt flags and reset requests itself.
`timescale 1ns/10ps
module sleep_wake_controller_tb;
  localparam int WDT_LIM = 20;
  localparam logic [7:0] A_ST = swc_pkg::SWC_OFS_STATUS;
  localparam logic [7:0] A_IC = swc_pkg::SWC_OFS_INTCTL;
  localparam logic [7:0] A_IE = swc_pkg::SWC_OFS_IRQEN;
  localparam logic [7:0] A_CF = swc_pkg::SWC_OFS_CONFIG;
  localparam logic [32:0] M_ALL = {33{1'b1}};
  localparam logic [32:0] M_ERR = {1'b1, 32'h0};
  localparam logic [32:0] M_FLG = {1'b1, 32'h18};
  logic pclk, presetn, psel, penable, pwrite, sleep_exec, ext_reset_req, brownout_req, por_req;
  logic [7:0] paddr, irq_flags;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, cpu_clk_gate, core_reset, wdt_reset, prefetch_req, wake_resume, isr_call;
  logic io_hold, lf_osc_run, timer_osc_run, adc_rc_run;
  logic [12:0] isr_vector;
  logic [32:0] exp_q[$], msk_q[$];
  logic isr_q[$];
  int n_fail, n_tests, seed, cnt, n_pf, n_crst, n_wdr, pf0, cr0, lo;
  swc_sleep_ctrl #(.IRQ_N(8), .WDT_W(16), .WDT_TIMEOUT(WDT_LIM)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .irq_flags(irq_flags), .ext_reset_req(ext_reset_req), .brownout_req(brownout_req), .por_req(por_req),
    .cpu_clk_gate(cpu_clk_gate), .core_reset(core_reset), .wdt_reset(wdt_reset), .prefetch_req(prefetch_req),
    .wake_resume(wake_resume), .isr_call(isr_call), .isr_vector(isr_vector), .io_hold(io_hold),
    .lf_osc_run(lf_osc_run), .timer_osc_run(timer_osc_run), .adc_rc_run(adc_rc_run)
  );
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Every transfer notes its expected {pslverr, prdata} under a mask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      check("apb wait", 33'h0, 33'h1);
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic go_sleep();
    @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask : go_sleep
  // sel 0: gate closed, 1: wake pulse, 2: core reset
  task automatic wait_for(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge pclk);
      n++;
      hit = (sel == 0) ? cpu_clk_gate === 1'b1 : (sel == 1) ? wake_resume === 1'b1 : core_reset === 1'b1;
    end
    if (!hit) begin
      check("wait bound", 33'h0, 33'h1);
      report_and_stop();
    end
  endtask : wait_for
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (prefetch_req === 1'b1) n_pf++;
    if (core_reset === 1'b1) n_crst++;
    if (wdt_reset === 1'b1) n_wdr++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) check("apb unexpected", 33'h0, 33'h1);
      else check("apb", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    if (wake_resume === 1'b1) begin
      if (isr_q.size() == 0) check("wake unexpected", 33'h0, 33'h1);
      else check("isr_call", {32'h0, isr_call}, {32'h0, isr_q.pop_front()});
    end
  end
  initial begin
    {n_fail, n_tests, n_pf, n_crst, n_wdr, seed} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd61};
    {presetn, psel, penable, pwrite, sleep_exec, ext_reset_req, brownout_req, por_req} = 8'h00;
    {paddr, irq_flags, pwdata} = 48'h0;
    repeat (2) @(posedge pclk);
    check("core_reset in reset", {32'h0, core_reset}, 33'h1);
    presetn <= 1'b1;
    apb(1'b0, A_ST, 32'h0, 33'h18, M_FLG);
    apb(1'b0, A_CF, 32'h0, 33'h18, M_ALL);
    apb(1'b0, 8'h14, 32'h0, M_ERR, M_ALL);
    apb(1'b1, 8'h14, 32'h0, M_ERR, M_ERR);
    apb(1'b1, A_ST, 32'h0, 33'h0, M_ERR);
    apb(1'b0, A_ST, 32'h0, 33'h18, M_FLG);
    rnd = $random(seed);
    apb(1'b1, A_IE, rnd, 33'h0, M_ERR);
    apb(1'b0, A_IE, 32'h0, {25'h0, rnd[7:0]}, M_ALL);
    check("isr_vector", {20'h0, isr_vector}, {20'h0, swc_pkg::SWC_ISR_VECTOR});
    $display("test registers done");
    apb(1'b1, A_IE, 32'h01, 33'h0, M_ERR);
    apb(1'b1, A_IC, 32'h80, 33'h0, M_ERR);
    check("gate awake", {32'h0, cpu_clk_gate}, 33'h0);
    pf0 = n_pf;
    go_sleep();
    wait_for(0, 4, cnt);
    check("io_hold", {32'h0, io_hold}, 33'h1);
    check("osc run", {30'h0, lf_osc_run, timer_osc_run, adc_rc_run}, 33'h7);
    apb(1'b0, swc_pkg::SWC_OFS_STATE, 32'h0, {30'h0, 1'b1, 2'(swc_pkg::SWC_SLEEP)}, M_ALL);
    apb(1'b0, A_ST, 32'h0, 33'h10, M_FLG);
    irq_flags <= 8'h02;
    repeat (10) @(posedge pclk);
    check("gate masked irq", {32'h0, cpu_clk_gate}, 33'h1);
    check("prefetch", n_pf - pf0, 33'h1);
    isr_q.push_back(1'b1);
    irq_flags <= 8'h03;
    wait_for(1, 10, cnt);
    check("gate open", {32'h0, cpu_clk_gate}, 33'h0);
    irq_flags <= 8'h00;
    $display("test interrupt wake done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_IE, 32'h01, 33'h0, M_ERR);
    apb(1'b1, A_IC, 32'h00, 33'h0, M_ERR);
    irq_flags <= 8'h01;
    go_sleep();
    repeat (4) @(posedge pclk);
    check("no-op gate", {32'h0, cpu_clk_gate}, 33'h0);
    apb(1'b0, A_ST, 32'h0, 33'h18, M_FLG);
    irq_flags <= 8'h00;
    $display("test no-op done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CF, 32'h18 | (m << 1), 33'h0, M_ERR);
      go_sleep();
      wait_for(0, 4, cnt);
      isr_q.push_back(1'b0);
      irq_flags <= 8'h01;
      wait_for(1, 1100, cnt);
      irq_flags <= 8'h00;
      lo = (m == 0) ? 0 : swc_pkg::SWC_OST_TOSC;
      check("wake delay", {32'h0, cnt >= lo && cnt <= lo + 6}, 33'h1);
      apb(1'b0, A_ST, 32'h0, 33'h10, M_FLG);
    end
    $display("test oscillator modes done");
    cr0 = n_crst;
    apb(1'b1, A_CF, 32'h19, 33'h0, M_ERR);
    go_sleep();
    wait_for(0, 4, cnt);
    isr_q.push_back(1'b0);
    wait_for(1, WDT_LIM + 10, cnt);
    apb(1'b1, A_CF, 32'h18, 33'h0, M_ERR);
    check("watchdog delay", {32'h0, cnt >= WDT_LIM - 2}, 33'h1);
    check("no core reset", n_crst - cr0, 33'h0);
    apb(1'b0, A_ST, 32'h0, 33'h00, M_FLG);
    $display("test watchdog wake done");
    apb(1'b1, A_CF, 32'h00, 33'h0, M_ERR);
    go_sleep();
    wait_for(0, 4, cnt);
    {ext_reset_req, brownout_req} <= 2'b11;
    repeat (6) @(posedge pclk);
    check("resets disabled", {31'h0, cpu_clk_gate, core_reset}, 33'h2);
    {ext_reset_req, brownout_req} <= 2'b00;
    apb(1'b1, A_CF, 32'h18, 33'h0, M_ERR);
    for (int s = 0; s < 3; s++) begin
      if (cpu_clk_gate !== 1'b1) go_sleep();
      wait_for(0, 4, cnt);
      {ext_reset_req, brownout_req, por_req} <= 3'b100 >> s;
      wait_for(2, 4, cnt);
      {ext_reset_req, brownout_req, por_req} <= 3'b000;
      repeat (2) @(posedge pclk);
      check("gate after reset", {32'h0, cpu_clk_gate}, 33'h0);
    end
    apb(1'b0, A_ST, 32'h0, 33'h18, M_FLG);
    $display("test reset wake done");
    cr0 = n_wdr;
    apb(1'b1, A_CF, 32'h19, 33'h0, M_ERR);
    repeat (WDT_LIM + 10) @(posedge pclk);
    apb(1'b1, A_CF, 32'h18, 33'h0, M_ERR);
    check("wdt_reset pulses", n_wdr - cr0, 33'h1);
    apb(1'b0, A_ST, 32'h0, 33'h08, M_FLG);
    $display("test watchdog run done");
    repeat (2) @(posedge pclk);
    report_and_stop();
  end
endmodule : sleep_wake_controller_tb
